// ---- rtl/phyirq_pkg.sv ----
/*
 * Package for the PHY interrupt reason and enable block: expanded register
 * offsets, bit positions, reset values and the packed status carrier.
 * Assumes the expanded memory window decoder hands over 16-bit addresses
 * and 8-bit data with single-cycle read and write strobes.
 */
// Notes on behaviour
// R1: Snapshot A bit 6 captures autonegotiation complete when the interrupt asserts.
// R2: Snapshot A bit 5 captures autonegotiation remote fault at interrupt assertion.
// R3: Snapshot A bits 4:3 capture resolved speed at assertion, only with link up.
// R4: Snapshot A bit 2 captures resolved link status at interrupt assertion.
// R5: Snapshot A bit 1 captures resolved duplex at assertion, only with link up.
// R6: Snapshot A bit 0 captures jabber status at interrupt assertion.
// R7: Snapshot B bit 7 captures gigabit configuration fault at assertion.
// R8: Snapshot B bit 6 captures gigabit status bit 14 at assertion with link up.
// R9: Snapshot B bits 5 and 4 capture local and remote receiver status.
// R10: Live reason A shows current autoneg complete, far fault, link and jabber.
// R11: Live speed follows resolved speed with link up, else holds last linked value.
// R12: Live duplex follows resolved duplex with link up, else holds last value.
// R13: Live reason B shows gigabit status bits 15 to 12 in bits 7 to 4.
// R14: Enable A bits 7..5 gate count threshold, autoneg complete, far fault; reset 0.
// R15: Enable A bits 4..0 gate speed, link threshold, link, duplex, jabber.
// R16: Enable B bits 6..3 gate config, local, remote receiver, idle threshold; bit 7 fixed.
// R17: Enable B bits 2, 1, 0 gate firmware ROM, firmware RAM and reset sequence.
// R18: Snapshots hold from one assertion to the next and reset to zero.
// R19: Interrupt asserts when any latched status meets its enable; snapshot on that edge.
// R20: Reserved bits read zero and ignore writes.
// R21: Latched status sets on change or threshold hit and stays set until software writes one to clear; firmware bits B 2 and 1 only mirror.
// R22: Interrupt pin driven only in interrupt mode; polarity selects active level.
// R23: Host reaches the 8-bit registers through the expanded address pointer and data.
package phyirq_pkg;

   localparam logic [15:0] OFS_SNAP_A   = 16'h810f;
   localparam logic [15:0] OFS_SNAP_B   = 16'h8110;
   localparam logic [15:0] OFS_LIVE_A   = 16'h8111;
   localparam logic [15:0] OFS_LIVE_B   = 16'h8112;
   localparam logic [15:0] OFS_EN_A     = 16'h8113;
   localparam logic [15:0] OFS_EN_B     = 16'h8114;
   localparam logic [15:0] OFS_CLR_A    = 16'h8115;
   localparam logic [15:0] OFS_CLR_B    = 16'h8116;
   localparam logic [15:0] OFS_PIN_CTL  = 16'h8117;

   localparam logic [7:0]  RST_EN_A     = 8'h00;
   localparam logic [7:0]  RST_EN_B     = 8'h00;
   localparam logic [7:0]  RST_SNAP     = 8'h00;
   localparam logic [7:0]  RST_PIN_CTL  = 8'h00;
   localparam logic [7:0]  RST_STAT_A   = 8'h00;
   localparam logic [7:0]  RST_STAT_B   = 8'h01;

   localparam logic [7:0]  MASK_EN_B    = 8'h7f;
   localparam logic [7:0]  MASK_CLR_B   = 8'h79;
   localparam logic [7:0]  MASK_PIN_CTL = 8'h05;
   localparam logic [7:0]  MASK_A_SRC   = 8'h76;

   localparam int          BIT_MODE     = 2;
   localparam int          BIT_POL      = 0;
   localparam int          BIT_FW_ROM   = 2;
   localparam int          BIT_FW_RAM   = 1;

   localparam int          GIG_CFG_FAULT = 15;
   localparam int          GIG_MASTER    = 14;
   localparam int          GIG_LOC_RCVR  = 13;
   localparam int          GIG_REM_RCVR  = 12;

   typedef struct packed {
      logic       autoneg_done_flag;
      logic       autoneg_far_fault_flag;
      logic [1:0] speed;
      logic       link;
      logic       duplex;
      logic       jabber;
   } phyirq_link_s;

endpackage

// ---- rtl/phyirq_core.sv ----
/*
 * PHY interrupt reason capture, live reason view, latched status,
 * source enables, clear registers and interrupt pin control.
 * Assumes status inputs come from logic on SYS_CLK_I and the expanded
 * memory decoder issues one-cycle strobes; read data is registered.
 */
`timescale 1ns/10ps
module phyirq_core
(
   input  wire logic                     SYS_CLK_I,        // Core clock, 25 MHz.
   input  wire logic                     ARST_N_I,         // Asynchronous reset, active low.
   input  wire phyirq_pkg::phyirq_link_s LINK_STAT_I,      // Link and autoneg status.
   input  wire logic [15:0]              GIG_STAT_I,       // Gigabit status register.
   input  wire logic                     AN_THRESH_HIT_I,  // Autoneg count over limit.
   input  wire logic                     LINK_THRESH_HIT_I,// Link count over limit.
   input  wire logic                     IEC_THRESH_HIT_I, // Idle error count over limit.
   input  wire logic                     FW_ROM_RUN_I,     // Firmware runs from ROM.
   input  wire logic                     RESET_SEQ_I,      // Firmware passed reset sequence.
   input  wire logic [15:0]              EXP_ADDR_I,       // Expanded address pointer.
   input  wire logic [7:0]               EXP_WDATA_I,      // Expanded write data.
   input  wire logic                     EXP_WR_I,         // Write strobe, one cycle.
   input  wire logic                     EXP_RD_I,         // Read strobe, one cycle.
   output logic      [7:0]               EXP_RDATA_O,      // Registered read data.
   output logic                          IRQ_O,            // Interrupt pin level.
   output logic                          IRQ_OE_O          // Interrupt pin enable.
);

   logic [7:0]                 en_a_q;
   logic [7:0]                 en_b_q;
   logic [7:0]                 stat_a_q;
   logic [7:0]                 stat_b_q;
   logic [7:0]                 stat_a_set;
   logic [7:0]                 stat_b_set;
   logic [7:0]                 clr_a;
   logic [7:0]                 clr_b;
   logic [7:0]                 snap_a_q;
   logic [7:0]                 snap_b_q;
   logic [7:0]                 pin_ctl_q;
   logic [7:0]                 live_a;
   logic [7:0]                 live_b;
   logic [2:0]                 kept_q;
   phyirq_pkg::phyirq_link_s   prev_link_q;
   logic [3:0]                 prev_gig_q;
   logic                       prev_fw_q;
   logic                       prev_rst_q;
   logic                       irq_req;
   logic                       irq_req_q;
   logic                       irq_rise;

   // The address comes in as an argument so a continuous assignment sees it change.
   function automatic logic hit(input logic [15:0] adr, input logic [15:0] ofs);
      hit = (adr == ofs);
   endfunction

   // Write-one clears are self-clearing: they act only in the strobe cycle.
   assign clr_a = (EXP_WR_I && hit(EXP_ADDR_I, phyirq_pkg::OFS_CLR_A)) ? EXP_WDATA_I : 8'h00;
   assign clr_b = (EXP_WR_I && hit(EXP_ADDR_I, phyirq_pkg::OFS_CLR_B)) ?
                  (EXP_WDATA_I & phyirq_pkg::MASK_CLR_B) : 8'h00;

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         en_a_q    <= phyirq_pkg::RST_EN_A;
         en_b_q    <= phyirq_pkg::RST_EN_B;
         pin_ctl_q <= phyirq_pkg::RST_PIN_CTL;
      end
      else if (EXP_WR_I)
      begin
         if (hit(EXP_ADDR_I, phyirq_pkg::OFS_EN_A))
            en_a_q <= EXP_WDATA_I; // R14 R15
         if (hit(EXP_ADDR_I, phyirq_pkg::OFS_EN_B))
            en_b_q <= EXP_WDATA_I & phyirq_pkg::MASK_EN_B; // R16 R17 R20
         if (hit(EXP_ADDR_I, phyirq_pkg::OFS_PIN_CTL))
            pin_ctl_q <= EXP_WDATA_I & phyirq_pkg::MASK_PIN_CTL; // R20
      end
   end

   // Previous-cycle copies for change detection.
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         prev_link_q <= '0;
         prev_gig_q  <= 4'h0;
         prev_fw_q   <= 1'b0;
         prev_rst_q  <= 1'b0;
      end
      else
      begin
         prev_link_q <= LINK_STAT_I;
         prev_gig_q  <= GIG_STAT_I[15:12];
         prev_fw_q   <= FW_ROM_RUN_I;
         prev_rst_q  <= RESET_SEQ_I;
      end
   end

   always_comb
   begin
      stat_a_set    = 8'h00;
      stat_a_set[7] = AN_THRESH_HIT_I;
      stat_a_set[6] = LINK_STAT_I.autoneg_done_flag != prev_link_q.autoneg_done_flag;
      stat_a_set[5] = LINK_STAT_I.autoneg_far_fault_flag != prev_link_q.autoneg_far_fault_flag;
      stat_a_set[4] = LINK_STAT_I.link && (LINK_STAT_I.speed != prev_link_q.speed);
      stat_a_set[3] = LINK_THRESH_HIT_I;
      stat_a_set[2] = LINK_STAT_I.link != prev_link_q.link;
      stat_a_set[1] = LINK_STAT_I.link && (LINK_STAT_I.duplex != prev_link_q.duplex);
      stat_a_set[0] = LINK_STAT_I.jabber != prev_link_q.jabber;
      stat_b_set    = 8'h00;
      stat_b_set[6] = LINK_STAT_I.link && (GIG_STAT_I[14] != prev_gig_q[2]);
      stat_b_set[5] = GIG_STAT_I[13] != prev_gig_q[1];
      stat_b_set[4] = GIG_STAT_I[12] != prev_gig_q[0];
      stat_b_set[3] = IEC_THRESH_HIT_I;
      stat_b_set[0] = RESET_SEQ_I && !prev_rst_q;
   end

   // A set arriving with its clear wins, so no event is lost.
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         stat_a_q <= phyirq_pkg::RST_STAT_A;
         stat_b_q <= phyirq_pkg::RST_STAT_B;
      end
      else
      begin
         stat_a_q <= (stat_a_q & ~clr_a) | stat_a_set; // R21
         stat_b_q[7] <= 1'b0;
         stat_b_q[6:3] <= (stat_b_q[6:3] & ~clr_b[6:3]) | stat_b_set[6:3]; // R21
         // The firmware flags mirror where the firmware runs; they have no clear.
         stat_b_q[phyirq_pkg::BIT_FW_ROM] <= FW_ROM_RUN_I;
         stat_b_q[phyirq_pkg::BIT_FW_RAM] <= !FW_ROM_RUN_I && prev_fw_q == FW_ROM_RUN_I;
         stat_b_q[0] <= (stat_b_q[0] & ~clr_b[0]) | stat_b_set[0]; // R21
      end
   end

   assign irq_req  = |(stat_a_q & en_a_q) || |(stat_b_q & en_b_q); // R19
   assign irq_rise = irq_req && !irq_req_q; // R19

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         irq_req_q <= 1'b0;
      else
         irq_req_q <= irq_req;
   end

   // Snapshots are taken only on the rising edge of the request and then hold.
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         snap_a_q <= phyirq_pkg::RST_SNAP; // R18
         snap_b_q <= phyirq_pkg::RST_SNAP; // R18
      end
      else if (irq_rise)
      begin
         snap_a_q[7] <= 1'b0; // R20
         snap_a_q[6] <= LINK_STAT_I.autoneg_done_flag; // R1
         snap_a_q[5] <= LINK_STAT_I.autoneg_far_fault_flag; // R2
         if (LINK_STAT_I.link)
         begin
            snap_a_q[4:3] <= LINK_STAT_I.speed; // R3
            snap_a_q[1]   <= LINK_STAT_I.duplex; // R5
            snap_b_q[6]   <= GIG_STAT_I[phyirq_pkg::GIG_MASTER]; // R8
         end
         snap_a_q[2] <= LINK_STAT_I.link; // R4
         snap_a_q[0] <= LINK_STAT_I.jabber; // R6
         snap_b_q[7] <= GIG_STAT_I[phyirq_pkg::GIG_CFG_FAULT]; // R7
         snap_b_q[5] <= GIG_STAT_I[phyirq_pkg::GIG_LOC_RCVR]; // R9
         snap_b_q[4] <= GIG_STAT_I[phyirq_pkg::GIG_REM_RCVR]; // R9
         snap_b_q[3:0] <= 4'h0; // R20
      end
   end

   // Speed and duplex last seen while linked, for the live view.
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         kept_q <= 3'h0;
      else if (LINK_STAT_I.link)
         kept_q <= {LINK_STAT_I.speed, LINK_STAT_I.duplex}; // R11 R12
   end

   always_comb
   begin
      live_a    = 8'h00;
      live_a[6] = LINK_STAT_I.autoneg_done_flag; // R10
      live_a[5] = LINK_STAT_I.autoneg_far_fault_flag; // R10
      live_a[4:3] = LINK_STAT_I.link ? LINK_STAT_I.speed : kept_q[2:1]; // R11
      live_a[2] = LINK_STAT_I.link; // R10
      live_a[1] = LINK_STAT_I.link ? LINK_STAT_I.duplex : kept_q[0]; // R12
      live_a[0] = LINK_STAT_I.jabber; // R10
      live_b    = {GIG_STAT_I[15:12], 4'h0}; // R13 R20
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         EXP_RDATA_O <= 8'h00;
      else if (EXP_RD_I)
      begin
         case (EXP_ADDR_I)
            phyirq_pkg::OFS_SNAP_A:  EXP_RDATA_O <= snap_a_q;
            phyirq_pkg::OFS_SNAP_B:  EXP_RDATA_O <= snap_b_q;
            phyirq_pkg::OFS_LIVE_A:  EXP_RDATA_O <= live_a;
            phyirq_pkg::OFS_LIVE_B:  EXP_RDATA_O <= live_b;
            phyirq_pkg::OFS_EN_A:    EXP_RDATA_O <= en_a_q;
            phyirq_pkg::OFS_EN_B:    EXP_RDATA_O <= en_b_q; // R20
            phyirq_pkg::OFS_PIN_CTL: EXP_RDATA_O <= pin_ctl_q;
            default:                 EXP_RDATA_O <= 8'h00;
         endcase
      end
   end

   // Pin drives only in interrupt mode; polarity one means active high.
   assign IRQ_OE_O = pin_ctl_q[phyirq_pkg::BIT_MODE]; // R22
   assign IRQ_O    = pin_ctl_q[phyirq_pkg::BIT_POL] ? irq_req : !irq_req; // R22

endmodule

// ---- testbench/phyirq_host_model.sv ----
/* Station management host model for the expanded register window.
   Assumes one shared clock and one-cycle read and write strobes. */
`timescale 1ns/10ps
module phyirq_host_model
(
   input  wire logic        clk_i,   // Core clock.
   input  wire logic [7:0]  rdata_i, // Registered read data.
   output logic      [15:0] addr_o,  // Expanded address pointer.
   output logic      [7:0]  wdata_o, // Expanded write data.
   output logic             wr_o,    // Write strobe.
   output logic             rd_o     // Read strobe.
);
   initial
   begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
   end
   // Released lines show the inverse so a stale value never passes as valid.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk_i) #1;
      addr_o = a;
      wdata_o = d;
      wr_o = w;
      rd_o = !w;
      @(posedge clk_i) #1;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
      q = rdata_i;
   endtask
endmodule

// ---- testbench/phyirq_core_assertions.sv ----
/* Port checker for phyirq_core, bound after the module.
   Assumes read data lands one cycle after its strobe. */
`timescale 1ns/10ps
module phyirq_core_assertions
(
   input wire logic                     SYS_CLK_I,   // Core clock.
   input wire logic                     ARST_N_I,    // Reset, active low.
   input wire phyirq_pkg::phyirq_link_s LINK_STAT_I, // Link status.
   input wire logic [15:0]              GIG_STAT_I,  // Gigabit status.
   input wire logic [15:0]              EXP_ADDR_I,  // Address pointer.
   input wire logic [7:0]               EXP_WDATA_I, // Write data.
   input wire logic                     EXP_WR_I,    // Write strobe.
   input wire logic                     EXP_RD_I,    // Read strobe.
   input wire logic [7:0]               EXP_RDATA_O, // Read data.
   input wire logic                     IRQ_OE_O     // Pin enable.
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   sequence s_wr(a);
      EXP_WR_I && EXP_ADDR_I == a;
   endsequence
   sequence s_rd(a);
      EXP_RD_I && EXP_ADDR_I == a;
   endsequence
   sequence s_wr_rd(a);
      s_wr(a) ##1 !EXP_WR_I ##1 s_rd(a);
   endsequence
   chk_en_a_back: assert property (
      s_wr_rd(phyirq_pkg::OFS_EN_A) |=> EXP_RDATA_O == $past(EXP_WDATA_I, 3))
      else $error("enable A readback wrong");
   chk_en_b_back: assert property (
      s_wr_rd(phyirq_pkg::OFS_EN_B)
      |=> EXP_RDATA_O == ($past(EXP_WDATA_I, 3) & phyirq_pkg::MASK_EN_B))
      else $error("enable B readback wrong");
   chk_live_a_view: assert property (
      s_rd(phyirq_pkg::OFS_LIVE_A) ##0 (LINK_STAT_I.link && $stable(LINK_STAT_I))
      |=> EXP_RDATA_O == {1'b0, $past(LINK_STAT_I)})
      else $error("live reason A wrong");
   chk_live_b_view: assert property (
      s_rd(phyirq_pkg::OFS_LIVE_B) |=> EXP_RDATA_O == {$past(GIG_STAT_I[15:12]), 4'h0})
      else $error("live reason B wrong");
   chk_unmapped_zero: assert property (
      EXP_RD_I && (EXP_ADDR_I < phyirq_pkg::OFS_SNAP_A || EXP_ADDR_I > 16'h811a)
      |=> EXP_RDATA_O == 8'h00) else $error("unmapped read not zero");
   chk_rdata_hold: assert property (!EXP_RD_I |=> $stable(EXP_RDATA_O))
      else $error("read data moved without a read");
   chk_oe_hold: assert property (
      !(EXP_WR_I && EXP_ADDR_I == phyirq_pkg::OFS_PIN_CTL) |=> $stable(IRQ_OE_O))
      else $error("pin enable moved without a write");
   chk_oe_update: assert property (
      s_wr(phyirq_pkg::OFS_PIN_CTL) |=> IRQ_OE_O == $past(EXP_WDATA_I[2]))
      else $error("pin enable not taken from mode bit");
endmodule
bind phyirq_core phyirq_core_assertions u_chk (.*);

// ---- testbench/testbench.sv ----
/* Self-checking bench for phyirq_core driven through the host model.
   Assumes a 25 MHz clock and registered read data. */
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR %0t: got %h want %h", $time, a, e); end end
module testbench;
   typedef struct packed {
      logic [15:0] adr;
      logic [7:0]  wd;
      logic [6:0]  ls;
      logic [3:0]  g;
      logic [7:0]  exp;
   } phyirq_row_s;
   phyirq_pkg::phyirq_link_s ls;
   logic [15:0]              gig, adr;
   logic [7:0]               wd, rdat, q;
   logic [2:0]               thr;
   logic                     clk, rst_n, wr, rd, irq, oe, fw, rseq;
   int                       n_fail, total_checks, cyc;
   phyirq_row_s rows [9] = '{'{16'h8113, 8'hff, 7'h00, 4'h0, 8'hff},
      '{16'h8113, 8'h5a, 7'h00, 4'h0, 8'h5a}, '{16'h8114, 8'hff, 7'h00, 4'h0, 8'h7f},
      '{16'h8114, 8'h00, 7'h00, 4'h0, 8'h00}, '{16'h8111, 8'hff, 7'h77, 4'h0, 8'h77},
      '{16'h8111, 8'h00, 7'h60, 4'h0, 8'h72}, '{16'h8112, 8'hff, 7'h60, 4'hf, 8'hf0},
      '{16'h8112, 8'h00, 7'h60, 4'h5, 8'h50}, '{16'h8000, 8'hff, 7'h60, 4'h5, 8'h00}};
   phyirq_core u_phyirq_core
   (
      .SYS_CLK_I(clk), .ARST_N_I(rst_n), .LINK_STAT_I(ls), .GIG_STAT_I(gig),
      .AN_THRESH_HIT_I(thr[2]), .LINK_THRESH_HIT_I(thr[1]), .IEC_THRESH_HIT_I(thr[0]),
      .FW_ROM_RUN_I(fw), .RESET_SEQ_I(rseq), .EXP_ADDR_I(adr), .EXP_WDATA_I(wd),
      .EXP_WR_I(wr), .EXP_RD_I(rd), .EXP_RDATA_O(rdat), .IRQ_O(irq), .IRQ_OE_O(oe)
   );
   phyirq_host_model u_phyirq_host_model
   (
      .clk_i(clk), .rdata_i(rdat), .addr_o(adr), .wdata_o(wd), .wr_o(wr), .rd_o(rd)
   );
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      u_phyirq_host_model.xfer(w, a, d, q);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
   endtask
   // Bounded so a dead request line cannot hang the run.
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 8)
      begin
         @(posedge clk) #1;
         n++;
      end
   endtask
   // One cycle of a threshold flag is enough to latch its status bit.
   task automatic thr_pulse(input logic [2:0] t);
      thr = t;
      @(posedge clk) #1;
      thr = 3'b000;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         summarize();
      end
   end
   initial
   begin
      ls = '0;
      gig = '0;
      thr = 3'b000;
      fw = 1'b0;
      rseq = 1'b0;
      do_reset();
      foreach (rows[i])
      begin
         ls = rows[i].ls;
         gig = {rows[i].g, 12'h000};
         acc(1'b1, rows[i].adr, rows[i].wd);
         rd_chk(rows[i].adr, rows[i].exp);
      end
      $display("register rows done");
      ls = '0;
      gig = '0;
      do_reset();
      `CHK({oe, irq}, 2'b01)
      rd_chk(16'h810f, 8'h00);
      rd_chk(16'h8110, 8'h00);
      rd_chk(16'h8113, 8'h00);
      rd_chk(16'h8114, 8'h00);
      $display("reset values done");
      acc(1'b1, 16'h8117, 8'h05);
      `CHK({oe, irq}, 2'b10)
      acc(1'b1, 16'h8113, 8'h04);
      ls = 7'h77;
      gig = 16'hf000;
      wait_irq(1'b1);
      `CHK(irq, 1'b1)
      rd_chk(16'h810f, 8'h77);
      rd_chk(16'h8110, 8'hf0);
      ls = 7'h37;
      repeat (3) @(posedge clk) #1;
      rd_chk(16'h810f, 8'h77);
      acc(1'b1, 16'h8115, 8'h04);
      wait_irq(1'b0);
      `CHK(irq, 1'b0)
      ls = 7'h00;
      wait_irq(1'b1);
      rd_chk(16'h810f, 8'h12);
      acc(1'b1, 16'h8117, 8'h04);
      `CHK({oe, irq}, 2'b10)
      acc(1'b1, 16'h8113, 8'h00);
      `CHK(irq, 1'b1)
      $display("interrupt capture done");
      acc(1'b1, 16'h8114, 8'h01);
      `CHK(irq, 1'b0)
      acc(1'b1, 16'h8116, 8'h01);
      `CHK(irq, 1'b1)
      rseq = 1'b1;
      wait_irq(1'b0);
      rseq = 1'b0;
      `CHK(irq, 1'b0)
      acc(1'b1, 16'h8116, 8'h01);
      acc(1'b1, 16'h8114, 8'h02);
      `CHK(irq, 1'b0)
      fw = 1'b1;
      wait_irq(1'b1);
      `CHK(irq, 1'b1)
      acc(1'b1, 16'h8114, 8'h04);
      `CHK(irq, 1'b0)
      acc(1'b1, 16'h8114, 8'h08);
      `CHK(irq, 1'b1)
      thr_pulse(3'b001);
      `CHK(irq, 1'b0)
      acc(1'b1, 16'h8114, 8'h00);
      acc(1'b1, 16'h8113, 8'h80);
      `CHK(irq, 1'b1)
      thr_pulse(3'b100);
      `CHK(irq, 1'b0)
      acc(1'b1, 16'h8115, 8'h80);
      acc(1'b1, 16'h8113, 8'h08);
      `CHK(irq, 1'b1)
      thr_pulse(3'b010);
      `CHK(irq, 1'b0)
      $display("firmware and threshold sources done");
      summarize();
   end
endmodule
